// ==== core/acp_serial_port.v ====
// serial read/write port of the eight-channel converter
`timescale 1ns/1ns
`include "acp_defs.vh"
module acp_serial_port #(
  parameter SCLK_HALF  = `ACP_SCLK_HALF_CYC,
  parameter FRAME_BITS = `ACP_FRAME_BITS
) (
  // clock and reset
  input  wire        clk,
  input  wire        arst_n,
  // static mode pin: low = device clocks, high = host clocks
  input  wire        clocking_mode_select,
  // serial clock pin
  input  wire        sclkIn,
  output reg         sclkOut,
  output reg         sclkOe,
  // read frame pin
  input  wire        readFrameNIn,
  output reg         readFrameNOut,
  output reg         readFrameNOe,
  // write frame and data pins
  input  wire        writeFrameN,
  input  wire        dataIn,
  output reg         dataOut,
  output reg         dataOutOe,
  // conversion engine side
  input  wire [11:0] resultData,
  input  wire        resultValid,
  output reg  [2:0]  channelSel,
  output reg         powerDown,
  output reg         convStart,
  output reg         ctrlUpdate,
  output reg         settleCharge
);

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  wire [4:0] syncBus;
  wire       modeExt;
  wire       sclkS;
  wire       readFrameNS;
  wire       writeFrameNS;
  wire       dataInS;

  acp_sync #(
    .WIDTH   (5)
  ) uSync (
    .clk     (clk),
    .arst_n  (arst_n),
    .asyncIn ({clocking_mode_select, sclkIn, readFrameNIn, writeFrameN, dataIn}),
    .syncOut (syncBus)
  );

  assign modeExt      = syncBus[4];
  assign sclkS        = syncBus[3];
  assign readFrameNS  = syncBus[2];
  assign writeFrameNS = syncBus[1];
  assign dataInS      = syncBus[0];

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  reg        sclkPrev_q;
  reg        readFramePrev_q;
  reg        writeFramePrev_q;
  reg [15:0] halfCnt_q;
  reg        selfRead_q;
  reg [2:0]  wrCnt_q;
  reg [4:0]  ctrlShift_q;
  reg [4:0]  bitCnt_q;
  reg        skipRise_q;
  reg [FRAME_BITS-1:0] outShift_q;
  reg [14:0] outReg_q;
  reg [14:0] holdWord_q;
  reg        pending_q;

  wire extRise;
  wire extFall;
  wire tick;
  wire selfRun;
  wire selfToggle;
  wire sclkRise;
  wire sclkFall;
  wire readBusy;
  wire readFrameFall;
  wire [FRAME_BITS-1:0] frameWord;

  // edges of the host clock, found on the sampled pin
  assign extRise = modeExt & sclkS & ~sclkPrev_q;
  assign extFall = modeExt & ~sclkS & sclkPrev_q;

  // own clock runs during a write frame or an own read frame
  assign tick       = (halfCnt_q == SCLK_HALF[15:0] - 16'h0001);
  assign selfRun    = ~modeExt & (~writeFrameNS | selfRead_q);
  assign selfToggle = tick & (selfRun | ~sclkOut);
  assign sclkRise   = modeExt ? extRise : (selfToggle & ~sclkOut);
  assign sclkFall   = modeExt ? extFall : (selfToggle & sclkOut);

  assign readBusy      = modeExt ? ~readFrameNS : selfRead_q;
  assign readFrameFall = modeExt & ~readFrameNS & readFramePrev_q;
  // leading zero, three address bits, result msb first
  assign frameWord     = {1'b0, outReg_q};

  // ------------------------------------------------------------------
  // pin history and own serial clock divider
  // ------------------------------------------------------------------
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sclkPrev_q       <= 1'b1;
      readFramePrev_q  <= 1'b1;
      writeFramePrev_q <= 1'b1;
      halfCnt_q        <= 16'h0000;
      sclkOut          <= 1'b1;
      sclkOe           <= 1'b0;
      readFrameNOe     <= 1'b0;
    end
    else
    begin
      sclkPrev_q       <= sclkS;
      readFramePrev_q  <= readFrameNS;
      writeFramePrev_q <= writeFrameNS;
      sclkOe           <= ~modeExt;
      readFrameNOe     <= ~modeExt;
      if (tick || (!selfRun && sclkOut))
        halfCnt_q <= 16'h0000;
      else
        halfCnt_q <= halfCnt_q + 16'h0001;
      if (selfToggle)
        sclkOut <= ~sclkOut;         // idles high between frames
    end
  end

  // ------------------------------------------------------------------
  // control register write
  // ------------------------------------------------------------------
  localparam [4:0] CTRL_RST    = `ACP_CTRL_RESET;
  localparam [2:0] COMMIT_EDGE = `ACP_COMMIT_EDGE;
  localparam [4:0] LAST_BIT    = FRAME_BITS[4:0];

  reg                  readBusyPrev_q;
  wire                 readEnd;
  wire                 writeFrameFall;
  wire [FRAME_BITS-1:0] freshWord;

  assign readEnd        = readBusyPrev_q & ~readBusy;
  assign writeFrameFall = ~writeFrameNS & writeFramePrev_q;
  assign freshWord      = {1'b0, channelSel, resultData};

  // five bits shift in on falling edges, the sixth falling edge commits
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wrCnt_q      <= 3'h0;
      ctrlShift_q  <= 5'h00;
      channelSel   <= CTRL_RST[`ACP_CTRL_CHAN_MSB:`ACP_CTRL_CHAN_LSB];
      powerDown    <= CTRL_RST[`ACP_CTRL_PDN_BIT];
      convStart    <= 1'b0;
      ctrlUpdate   <= 1'b0;
      settleCharge <= 1'b0;
    end
    else
    begin
      convStart  <= 1'b0;
      ctrlUpdate <= 1'b0;
      if (writeFrameNS)
        wrCnt_q <= 3'h0;
      else if (sclkFall && wrCnt_q <= COMMIT_EDGE)
      begin
        wrCnt_q <= wrCnt_q + 3'h1;                         // saturates at six
        if (wrCnt_q < COMMIT_EDGE)
          ctrlShift_q <= {ctrlShift_q[3:0], dataInS};
        else
        begin
          // sixth falling edge loads the register
          channelSel   <= ctrlShift_q[`ACP_CTRL_CHAN_MSB:`ACP_CTRL_CHAN_LSB];
          powerDown    <= ctrlShift_q[`ACP_CTRL_PDN_BIT];
          convStart    <= ctrlShift_q[`ACP_CTRL_CONV_BIT];
          ctrlUpdate   <= 1'b1;
          settleCharge <= 1'b0;                            // pulse starts to discharge
        end
      end
      // settle pulse charges when a write frame opens; set wins
      if (writeFrameFall)
        settleCharge <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // output register
  // ------------------------------------------------------------------
  // a result arriving during a read waits for the frame to end
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      readBusyPrev_q <= 1'b0;
      outReg_q       <= 15'h0000;
      holdWord_q     <= 15'h0000;
      pending_q      <= 1'b0;
    end
    else
    begin
      readBusyPrev_q <= readBusy;
      if (resultValid && readBusy)
      begin
        holdWord_q <= {channelSel, resultData};
        pending_q  <= 1'b1;
      end
      else if (resultValid)
      begin
        outReg_q  <= {channelSel, resultData};
        pending_q <= 1'b0;
      end
      else if (readEnd && pending_q)
      begin
        outReg_q  <= holdWord_q;
        pending_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // read frame shifter
  // ------------------------------------------------------------------
  // lead bit at frame start, rising edges launch the rest msb first
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      selfRead_q    <= 1'b0;
      readFrameNOut <= 1'b1;
      outShift_q    <= {FRAME_BITS{1'b0}};
      bitCnt_q      <= 5'h00;
      skipRise_q    <= 1'b0;
      dataOut       <= 1'b0;
      dataOutOe     <= 1'b0;
    end
    else if (!modeExt && !selfRead_q && resultValid)
    begin
      // own frame opens at end of conversion
      selfRead_q    <= 1'b1;
      readFrameNOut <= 1'b0;
      outShift_q    <= freshWord;
      bitCnt_q      <= 5'h01;
      skipRise_q    <= 1'b0;
      dataOut       <= freshWord[FRAME_BITS-1];
      dataOutOe     <= 1'b1;
    end
    else if (readFrameFall)
    begin
      // host frame: lead bit now, first rise repeats it if clock was low
      outShift_q <= frameWord;
      bitCnt_q   <= 5'h01;
      skipRise_q <= ~sclkS;
      dataOut    <= frameWord[FRAME_BITS-1];
      dataOutOe  <= 1'b1;                                  // only inside a read frame
    end
    else if (modeExt && readFrameNS)
      dataOutOe <= 1'b0;                                   // frame rise floats line
    else if (sclkRise && readBusy && dataOutOe)
    begin
      if (skipRise_q)
        skipRise_q <= 1'b0;
      else if (bitCnt_q == LAST_BIT)
      begin
        // edge after the last bit ends the transfer
        dataOutOe     <= 1'b0;
        selfRead_q    <= 1'b0;
        readFrameNOut <= 1'b1;
      end
      else
      begin
        // read keeps going past the control commit
        dataOut    <= outShift_q[FRAME_BITS-2];
        outShift_q <= {outShift_q[FRAME_BITS-2:0], 1'b0};
        bitCnt_q   <= bitCnt_q + 5'h01;
      end
    end
  end

endmodule

// ==== core/acp_defs.vh ====
// constants for the converter serial control port
`ifndef ACP_DEFS_VH
`define ACP_DEFS_VH

// ------------------------------------------------------------------
// control word layout
// ------------------------------------------------------------------
`define ACP_CTRL_BITS      5
`define ACP_CTRL_CHAN_MSB  4
`define ACP_CTRL_CHAN_LSB  2
`define ACP_CTRL_CONV_BIT  1
`define ACP_CTRL_PDN_BIT   0
`define ACP_CTRL_RESET     5'h00
`define ACP_COMMIT_EDGE    3'h5

// ------------------------------------------------------------------
// read frame layout and timing
// ------------------------------------------------------------------
`define ACP_FRAME_BITS     16
`define ACP_RESULT_BITS    12
`define ACP_CLK_MHZ        10
`define ACP_SCLK_HALF_NS   200
`define ACP_SCLK_HALF_CYC  ((`ACP_SCLK_HALF_NS * `ACP_CLK_MHZ) / 1000)

`endif

// ==== core/acp_sync.v ====
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module acp_sync #(
  parameter WIDTH = 1
) (
  // clock and reset
  input  wire             clk,
  input  wire             arst_n,
  // asynchronous inputs and synchronised copies
  input  wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] stage1_q;
  reg [WIDTH-1:0] stage2_q;

  // first stage feeds only the second stage
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stage1_q <= {WIDTH{1'b1}};
      stage2_q <= {WIDTH{1'b1}};
    end
    else
    begin
      stage1_q <= asyncIn;
      stage2_q <= stage1_q;
    end
  end

  assign syncOut = stage2_q;

endmodule

// ==== sim/acp_host_model.sv ====
// host serial port model: clock master with one shared frame
`timescale 1ns/1ns
module acp_host_model (
  // system clock
  input  wire clk,
  // host pins
  output reg  sclk,
  output reg  frameN,
  output reg  mosi,
  input  wire miso
);
  // idle: clock low, frame high
  initial
  begin
    sclk = 1'b0;
    frameN = 1'b1;
    mosi = 1'b0;
  end
  // one frame of n bits, launch on rise, sample on fall
  // word is in hand before the frame opens
  task xfer(input integer n, input [15:0] w, output [15:0] r);
    integer i;
    begin
      r = 16'h0000;
      @(negedge clk) frameN = 1'b0;
      for (i = 0; i < n; i = i + 1)
      begin
        repeat (4) @(negedge clk);
        sclk = 1'b1;
        mosi = w[15 - i];
        repeat (4) @(negedge clk);
        sclk = 1'b0;
        r = {r[14:0], miso};
      end
      repeat (4) @(negedge clk);
      frameN = 1'b1;
      repeat (8) @(negedge clk);
    end
  endtask
endmodule

// ==== sim/acp_serial_port_asserts.sv ====
// concurrent checks on the serial port outputs
`timescale 1ns/1ns
module acp_serial_port_asserts (
  // clock and reset
  input wire       clk,
  input wire       arst_n,
  // pins and control outputs
  input wire       clocking_mode_select,
  input wire       readFrameNIn,
  input wire       writeFrameN,
  input wire       sclkOe,
  input wire       readFrameNOe,
  input wire       dataOutOe,
  input wire [2:0] channelSel,
  input wire       powerDown,
  input wire       convStart,
  input wire       ctrlUpdate
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // frames quiet for eight cycles
  sequence readIdle;
    (clocking_mode_select && readFrameNIn) [*8];
  endsequence
  sequence writeIdle;
    writeFrameN [*8];
  endsequence
  chk_sclk_input: assert property (clocking_mode_select |-> !sclkOe)
    else $error("serial clock driven in host mode");
  chk_frame_input: assert property (clocking_mode_select |-> !readFrameNOe)
    else $error("read frame driven in host mode");
  chk_dout_float: assert property (readIdle |-> !dataOutOe)
    else $error("data out driven outside read frame");
  chk_no_update: assert property (writeIdle |-> !ctrlUpdate)
    else $error("update without write frame");
  chk_one_update: assert property (ctrlUpdate |=> !ctrlUpdate [*8])
    else $error("second update in frame");
  chk_chan_cause: assert property ($changed(channelSel) |-> ctrlUpdate || $past(ctrlUpdate))
    else $error("channel changed without update");
  chk_pdn_cause: assert property ($changed(powerDown) |-> ctrlUpdate || $past(ctrlUpdate))
    else $error("power down changed without update");
  chk_conv_cause: assert property ($rose(convStart) |-> ctrlUpdate || $past(ctrlUpdate))
    else $error("conversion start without update");
endmodule
bind acp_serial_port acp_serial_port_asserts u_chk (.*);

// ==== sim/acp_serial_port_test.sv ====
// self-checking bench for the serial control port
`timescale 1ns/1ns
module acp_serial_port_test;
  reg         clk = 1'b0;
  reg         arst_n = 1'b0;
  reg  [11:0] resultData = 12'h000;
  reg         resultValid = 1'b0;
  reg  [31:0] seed = 32'hF1755532;
  reg  [15:0] word;
  reg  [15:0] rd;
  reg  [2:0]  chan;
  reg         modeSel = 1'b1;
  reg  [15:0] expRd;
  wire        selfSclk, frameOutN;
  integer     failures = 0;
  integer     n_checks = 0;
  integer     k;
  wire        sclk, frameN, mosi, dOut, dOe, pdn;
  wire [2:0]  chSel;
  // released data line shows the inverse level
  wire        miso = dOe ? dOut : ~dOut;
  always #50 clk = ~clk;
  acp_host_model u_host (.clk(clk), .sclk(sclk), .frameN(frameN), .mosi(mosi), .miso(miso));
  acp_serial_port u_dut (.clk(clk), .arst_n(arst_n), .clocking_mode_select(modeSel),
    .sclkIn(sclk), .sclkOut(selfSclk), .sclkOe(), .readFrameNIn(frameN),
    .readFrameNOut(frameOutN),
    .readFrameNOe(), .writeFrameN(frameN), .dataIn(mosi), .dataOut(dOut),
    .dataOutOe(dOe), .resultData(resultData), .resultValid(resultValid),
    .channelSel(chSel), .powerDown(pdn), .convStart(), .ctrlUpdate(), .settleCharge());
  // xorshift step
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  // compare one value
  task check(input [15:0] got, input [15:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp)
      begin
        failures = failures + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // compare one control output
  task check_ctrl(input [3:0] got, input [3:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp)
      begin
        failures = failures + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // verdict and end of run
  task report_and_stop;
    begin
      if (failures == 0 && n_checks > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  // watchdog
  initial
  begin
    #3000000;
    failures = failures + 1;
    report_and_stop;
  end
  // combined frames over every channel, then a short frame
  initial
  begin
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    chan = 3'h0;
    for (k = 0; k < 8; k = k + 1)
    begin
      seed = xs(seed);
      word = {k[2:0], seed[12:0]};
      resultData = seed[27:16];
      @(negedge clk) resultValid = 1'b1;
      @(negedge clk) resultValid = 1'b0;
      expRd = {1'b0, chan, resultData};
      // frame done well before the next result
      repeat (4) @(negedge clk);
      u_host.xfer(16, word, rd);
      check(rd, {1'b0, chan, resultData});
      check_ctrl(chSel, word[15:13]);
      check_ctrl(pdn, word[11]);
      chan = word[15:13];
    end
    // result arriving mid-read is held until the frame rises
    seed = xs(seed);
    word = seed[15:0];
    resultData = seed[27:16];
    fork
      u_host.xfer(16, word, rd);
      begin
        repeat (100) @(negedge clk);
        resultValid = 1'b1;
        @(negedge clk) resultValid = 1'b0;
      end
    join
    check(rd, expRd);
    chan = word[15:13];
    expRd = {1'b0, chan, resultData};
    // short shared frame: no commit, five bits read
    u_host.xfer(5, ~word, rd);
    check_ctrl(chSel, chan);
    check(rd, {11'h000, expRd[15:11]});
    // own clocking: device frames and clocks the read
    modeSel = 1'b0;
    repeat (8) @(negedge clk);
    seed = xs(seed);
    resultData = seed[11:0];
    @(negedge clk) resultValid = 1'b1;
    @(negedge clk) resultValid = 1'b0;
    for (k = 0; k < 16; k = k + 1)
      @(negedge selfSclk) rd = {rd[14:0], miso};
    check(rd, {1'b0, chan, resultData});
    repeat (8) @(negedge clk);
    check_ctrl(frameOutN, 1'b1);
    report_and_stop;
  end
endmodule
